// File: design/tmc_regs.svh
// Register offsets, field positions, reset values and timing counts of the timer core.
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH
// ==========================================================================
// Register byte addresses.
`define TMC_CTRL0_OFS     12'h000
`define TMC_CTRL1_OFS     12'h004
`define TMC_CNT_LOW_OFS   12'h008
`define TMC_CNT_HIGH_OFS  12'h00C
`define TMC_CMPA_LOW_OFS  12'h010
`define TMC_CMPA_HIGH_OFS 12'h014
`define TMC_STATUS_OFS    12'h018
// ==========================================================================
// Control 0 field positions.
`define TMC_C0_PAUSE_BIT  7
`define TMC_C0_CKSEL_LSB  4
`define TMC_C0_ON_BIT     3
`define TMC_C0_CMPP_LSB   0
// Control 1 field positions.
`define TMC_C1_MODE_LSB   6
`define TMC_C1_PINF_LSB   4
`define TMC_C1_INIT_BIT   3
`define TMC_C1_POL_BIT    2
`define TMC_C1_DPX_BIT    1
`define TMC_C1_CCLR_BIT   0
// ==========================================================================
// Reset values.
`define TMC_CTRL_RST      8'h00
`define TMC_CNT_RST       10'h000
// ==========================================================================
// Divider counts for the internal clock sources (in system clocks).
`define TMC_DIV_SYS4      8'd4
`define TMC_DIV_H16       8'd16
`define TMC_DIV_H64       8'd64
`define TMC_DIV_SUB       8'd250
`endif

// File: design/tmc_pkg.sv
// Types shared by the timer core files.
package tmc_pkg;
   typedef enum logic [1:0] {
      TMC_MODE_CMP   = 2'h0,
      TMC_MODE_UNDEF = 2'h1,
      TMC_MODE_PWM   = 2'h2,
      TMC_MODE_TMR   = 2'h3
   } tmc_mode_t;
   typedef enum logic [1:0] {
      TMC_PIN_KEEP = 2'h0,
      TMC_PIN_LOW  = 2'h1,
      TMC_PIN_HIGH = 2'h2,
      TMC_PIN_TOG  = 2'h3
   } tmc_pin_t;
endpackage

// File: design/tmc_clk_sel.sv
// Counter clock enable selector with external input synchroniser and edge detect.
`timescale 1ns/100ps
`include "tmc_regs.svh"
module tmc_clk_sel
   import tmc_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [2:0] sel_i,
   input  wire logic       ext_i,
   output logic            tick_o,
   output logic            ext_rise_o
);
   // ==========================================================================
   // Synchroniser and prescaler state.
   logic [7:0] div_r,  div_nxt;
   logic       s1_r, s2_r, s3_r;
   logic       tick_nxt, rise_nxt;
   logic [7:0] lim;

   // Divide limit per source; the high and subsidiary clocks are modelled
   // as fixed ratios of the single system clock.
   always_comb begin
      case (sel_i)
         3'h0:    lim = `TMC_DIV_SYS4;
         3'h1:    lim = 8'd1;
         3'h2:    lim = `TMC_DIV_H16;
         3'h3:    lim = `TMC_DIV_H64;
         default: lim = `TMC_DIV_SUB;
      endcase
      div_nxt = (div_r + 8'd1 >= lim) ? 8'h00 : div_r + 8'd1;
      // Edges are taken from the second and third stages only.
      rise_nxt = s2_r & ~s3_r;
      if (sel_i == 3'h6) begin
         tick_nxt = rise_nxt;
      end else if (sel_i == 3'h7) begin
         tick_nxt = ~s2_r & s3_r;
      end else begin
         tick_nxt = (div_r + 8'd1 >= lim);
      end
   end

   // Registers only.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_r      <= 8'h00;
         s1_r       <= 1'b0;
         s2_r       <= 1'b0;
         s3_r       <= 1'b0;
         tick_o     <= 1'b0;
         ext_rise_o <= 1'b0;
      end else begin
         div_r      <= div_nxt;
         s1_r       <= ext_i;
         s2_r       <= s1_r;
         s3_r       <= s2_r;
         tick_o     <= tick_nxt;
         ext_rise_o <= rise_nxt;
      end
   end
endmodule

// File: design/tmc_core.sv
// Standard timer core: 10-bit counter, comparators A and P, output pair, APB registers.
`timescale 1ns/100ps
`include "tmc_regs.svh"
module tmc_core
   import tmc_pkg::*;
(
   input  wire logic        CLK_SYS_I,
   input  wire logic        SYS_RST_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [11:0] PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   input  wire logic        EXT_CLOCK_INPUT_I,
   output logic             OUT_TRUE_O,
   output logic             OUT_INVERTED_O,
   output logic             MATCH_A_IRQ_O,
   output logic             MATCH_P_IRQ_O
);
   // ==========================================================================
   // State.
   logic [7:0]  ctrl0_r, ctrl0_nxt;
   logic [7:0]  ctrl1_r, ctrl1_nxt;
   logic [9:0]  cmpa_r,  cmpa_nxt;
   logic [7:0]  hold_r,  hold_nxt;
   logic [9:0]  cnt_r,   cnt_nxt;
   logic        out_r,   out_nxt;
   logic        on_d_r,  on_d_nxt;
   logic        pulse_r, pulse_nxt;
   logic        irqa_nxt, irqp_nxt;
   logic [31:0] rdata_nxt;
   logic        rdy_nxt, err_nxt;
   logic        tick, ext_rise;
   logic        acc, wr, rd, mapped;
   logic        on_bit, on_rise, match_a, match_p, overflow, run;
   logic [2:0]  cmp_p;
   tmc_mode_t   mode;
   tmc_pin_t    pinf;
   logic        pwm_level;

   assign on_bit = ctrl0_r[`TMC_C0_ON_BIT];
   assign cmp_p  = ctrl0_r[`TMC_C0_CMPP_LSB +: 3];
   assign mode   = tmc_mode_t'(ctrl1_r[`TMC_C1_MODE_LSB +: 2]);
   assign pinf   = tmc_pin_t'(ctrl1_r[`TMC_C1_PINF_LSB +: 2]);

   // ==========================================================================
   // Clock source selection.
   tmc_clk_sel u_clk_sel (
      .clk_i      (CLK_SYS_I),
      .rst_i      (SYS_RST_I),
      .sel_i      (ctrl0_r[`TMC_C0_CKSEL_LSB +: 3]),
      .ext_i      (EXT_CLOCK_INPUT_I),
      .tick_o     (tick),
      .ext_rise_o (ext_rise)
   );

   // ==========================================================================
   // Bus decode; the slave answers with a registered ready one cycle after the access cycle.
   assign acc = PSEL_I & PENABLE_I & ~PREADY_O;
   assign wr  = acc & PWRITE_I;
   assign rd  = acc & ~PWRITE_I;
   always_comb begin
      case (PADDR_I)
         `TMC_CTRL0_OFS, `TMC_CTRL1_OFS, `TMC_CNT_LOW_OFS, `TMC_CNT_HIGH_OFS,
         `TMC_CMPA_LOW_OFS, `TMC_CMPA_HIGH_OFS, `TMC_STATUS_OFS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // ==========================================================================
   // Counter, comparators and output logic.
   always_comb begin
      on_rise   = on_bit & ~on_d_r;
      // Comparator P zero means a full 1024-clock period.
      match_p   = (cnt_r[9:7] == cmp_p) & (cmp_p != 3'h0);
      match_a   = (cnt_r == cmpa_r);
      overflow  = (cnt_r == 10'h3FF);
      // In single pulse mode the counter waits for the trigger.
      run       = on_bit & ~ctrl0_r[`TMC_C0_PAUSE_BIT] & tick
                  & ((mode != TMC_MODE_PWM) || (pinf != TMC_PIN_TOG) || pulse_r);
      cnt_nxt   = cnt_r;
      out_nxt   = out_r;
      pulse_nxt = pulse_r;
      irqa_nxt  = 1'b0;
      irqp_nxt  = 1'b0;
      pwm_level = ~ctrl1_r[`TMC_C1_POL_BIT];
      if (on_rise) begin
         cnt_nxt = `TMC_CNT_RST;
         if (mode == TMC_MODE_CMP) begin
            out_nxt = ctrl1_r[`TMC_C1_INIT_BIT];
         end
      end else if (run) begin
         irqa_nxt = match_a;
         irqp_nxt = match_p;
         // Match selected by the clear bit restarts the count.
         if (overflow || (ctrl1_r[`TMC_C1_CCLR_BIT] ? match_a : match_p)) begin
            cnt_nxt = `TMC_CNT_RST;
         end else begin
            cnt_nxt = cnt_r + 10'h001;
         end
         case (mode)
            TMC_MODE_CMP: begin
               if (match_a) begin
                  case (pinf)
                     TMC_PIN_LOW:  out_nxt = 1'b0;
                     TMC_PIN_HIGH: out_nxt = 1'b1;
                     TMC_PIN_TOG:  out_nxt = ~out_r;
                     default:      out_nxt = out_r;
                  endcase
               end
            end
            TMC_MODE_PWM: begin
               // Edge aligned: active from period start until the duty match.
               // Except in single pulse mode, where A ends it, the duplex bit picks which comparator ends the active level (P when set, A when clear).
               if (pinf == TMC_PIN_TOG) begin
                  if (match_a) begin
                     pulse_nxt = 1'b0;
                     out_nxt   = ~pwm_level;
                  end
               end else if (ctrl1_r[`TMC_C1_DPX_BIT] ? match_p : match_a) begin
                  out_nxt = (pinf == TMC_PIN_TOG) ? out_r : ~pwm_level;
               end else if (cnt_nxt == `TMC_CNT_RST) begin
                  out_nxt = pwm_level;
               end
            end
            default: out_nxt = out_r;
         endcase
      end
      // Fixed-level PWM selections and the single pulse trigger.
      if (mode == TMC_MODE_PWM) begin
         case (pinf)
            TMC_PIN_KEEP: out_nxt = ~pwm_level;
            TMC_PIN_LOW:  out_nxt = pwm_level;
            TMC_PIN_TOG: begin
               if (ext_rise && on_bit && !pulse_r) begin
                  pulse_nxt = 1'b1;
                  out_nxt   = pwm_level;
                  cnt_nxt   = `TMC_CNT_RST;
               end
            end
            default: out_nxt = out_nxt;
         endcase
      end
      on_d_nxt = on_bit;
   end

   // ==========================================================================
   // Register file with the shared low-byte holding buffer.
   always_comb begin
      ctrl0_nxt = ctrl0_r;
      ctrl1_nxt = ctrl1_r;
      cmpa_nxt  = cmpa_r;
      hold_nxt  = hold_r;
      rdata_nxt = 32'h0000_0000;
      rdy_nxt   = acc;
      err_nxt   = acc & ~mapped;
      if (wr) begin
         case (PADDR_I)
            `TMC_CTRL0_OFS:    ctrl0_nxt = PWDATA_I[7:0];
            `TMC_CTRL1_OFS:    ctrl1_nxt = PWDATA_I[7:0];
            `TMC_CMPA_LOW_OFS: hold_nxt  = PWDATA_I[7:0];
            `TMC_CMPA_HIGH_OFS: cmpa_nxt = {PWDATA_I[1:0], hold_r};
            default:           hold_nxt  = hold_r;
         endcase
      end
      if (rd) begin
         case (PADDR_I)
            `TMC_CTRL0_OFS: rdata_nxt = {24'h000000, ctrl0_r};
            `TMC_CTRL1_OFS: rdata_nxt = {24'h000000, ctrl1_r};
            `TMC_CNT_HIGH_OFS: begin
               rdata_nxt = {30'h00000000, cnt_r[9:8]};
               hold_nxt  = cnt_r[7:0];
            end
            `TMC_CMPA_HIGH_OFS: begin
               rdata_nxt = {30'h00000000, cmpa_r[9:8]};
               hold_nxt  = cmpa_r[7:0];
            end
            `TMC_CNT_LOW_OFS, `TMC_CMPA_LOW_OFS:
               rdata_nxt = {24'h000000, hold_r};
            `TMC_STATUS_OFS: rdata_nxt = {30'h00000000, pulse_r, out_r};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   // Registers only; every output comes from a flip-flop.
   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         ctrl0_r        <= `TMC_CTRL_RST;
         ctrl1_r        <= `TMC_CTRL_RST;
         cmpa_r         <= `TMC_CNT_RST;
         hold_r         <= 8'h00;
         cnt_r          <= `TMC_CNT_RST;
         out_r          <= 1'b0;
         on_d_r         <= 1'b0;
         pulse_r        <= 1'b0;
         PRDATA_O       <= 32'h0000_0000;
         PREADY_O       <= 1'b0;
         PSLVERR_O      <= 1'b0;
         OUT_TRUE_O     <= 1'b0;
         OUT_INVERTED_O <= 1'b1;
         MATCH_A_IRQ_O  <= 1'b0;
         MATCH_P_IRQ_O  <= 1'b0;
      end else begin
         ctrl0_r        <= ctrl0_nxt;
         ctrl1_r        <= ctrl1_nxt;
         cmpa_r         <= cmpa_nxt;
         hold_r         <= hold_nxt;
         cnt_r          <= cnt_nxt;
         out_r          <= out_nxt;
         on_d_r         <= on_d_nxt;
         pulse_r        <= pulse_nxt;
         PRDATA_O       <= rdata_nxt;
         PREADY_O       <= rdy_nxt;
         PSLVERR_O      <= err_nxt;
         OUT_TRUE_O     <= out_nxt;
         OUT_INVERTED_O <= ~out_nxt;
         MATCH_A_IRQ_O  <= irqa_nxt;
         MATCH_P_IRQ_O  <= irqp_nxt;
      end
   end
endmodule

// File: test/tmc_core_properties.sv
// Concurrent checks on the ports of the standard timer core.
`timescale 1ns/100ps
module tmc_core_properties (
   input wire logic        CLK_SYS_I,
   input wire logic        SYS_RST_I,
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic        PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic        PREADY_O,
   input wire logic        PSLVERR_O,
   input wire logic        EXT_CLOCK_INPUT_I,
   input wire logic        OUT_TRUE_O,
   input wire logic        OUT_INVERTED_O,
   input wire logic        MATCH_A_IRQ_O,
   input wire logic        MATCH_P_IRQ_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (SYS_RST_I);
   // ==========================================================================
   // Steps of a bus access as the slave sees them.
   sequence s_take;
      PSEL_I && PENABLE_I && !PREADY_O;
   endsequence
   sequence s_hi_read;
      s_take ##0 (!PWRITE_I && (PADDR_I == 12'h00C || PADDR_I == 12'h014));
   endsequence
   // ==========================================================================
   // Pin pair, reset state and bus answers.
   property p_pair;
      OUT_INVERTED_O == !OUT_TRUE_O;
   endproperty
   property p_rst_vals;
      $fell(SYS_RST_I) |-> !OUT_TRUE_O && !PREADY_O && !MATCH_A_IRQ_O && !MATCH_P_IRQ_O;
   endproperty
   property p_answer;
      s_take |=> PREADY_O;
   endproperty
   property p_pulse;
      PREADY_O |=> !PREADY_O;
   endproperty
   property p_cause;
      PREADY_O |-> $past(PSEL_I) && $past(PENABLE_I);
   endproperty
   property p_err_ready;
      PSLVERR_O |-> PREADY_O;
   endproperty
   property p_unmapped;
      s_take ##0 (PADDR_I > 12'h018) |=> PSLVERR_O && PRDATA_O == 32'h0;
   endproperty
   property p_mapped;
      s_take ##0 (PADDR_I <= 12'h018 && PADDR_I[1:0] == 2'h0) |=> !PSLVERR_O;
   endproperty
   property p_hi_read;
      s_hi_read |=> PRDATA_O[31:2] == 30'h0;
   endproperty
   a_pair:      assert property (p_pair) else $error("output pair not inverse");
   a_rst_vals:  assert property (p_rst_vals) else $error("bad reset state");
   a_answer:    assert property (p_answer) else $error("no ready after access");
   a_pulse:     assert property (p_pulse) else $error("ready longer than one cycle");
   a_cause:     assert property (p_cause) else $error("ready without access");
   a_err_ready: assert property (p_err_ready) else $error("error without ready");
   a_unmapped:  assert property (p_unmapped) else $error("unmapped not refused");
   a_mapped:    assert property (p_mapped) else $error("mapped access refused");
   a_hi_read:   assert property (p_hi_read) else $error("high byte too wide");
endmodule

// File: test/tmc_ext_src.sv
// Model of the outside signal source that drives the external clock input.
`timescale 1ns/100ps
module tmc_ext_src (
   input  wire logic       clk_i,
   input  wire logic       start_i,
   input  wire logic [7:0] count_i,
   input  wire logic [3:0] half_i,
   output logic            ext_o,
   output logic            busy_o
);
   logic [7:0] left_r = 8'h00;
   logic [3:0] tim_r = 4'h0;
   logic       lvl_r = 1'b0;
   // ==========================================================================
   // Pulse train; each level lasts half_i+1 cycles so slow and quick sources can be tried.
   // The level lives in one register so the pin has a single driver from time zero.
   always @(posedge clk_i) begin
      if (start_i) begin
         left_r <= count_i;
         tim_r <= half_i;
      end else if (left_r != 8'h00) begin
         if (tim_r != 4'h0) begin
            tim_r <= tim_r - 4'h1;
         end else begin
            tim_r <= half_i;
            lvl_r <= !lvl_r;
            if (lvl_r) begin
               left_r <= left_r - 8'h01;
            end
         end
      end
   end
   // The source is busy while pulses remain; the line idles low between trains.
   assign busy_o = (left_r != 8'h00);
   assign ext_o  = lvl_r;
endmodule

// File: test/tmc_core_test.sv
// Self-checking testbench of the standard timer core.
`timescale 1ns/100ps
`include "tmc_regs.svh"
module tmc_core_test import tmc_pkg::*;;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        perr;
   logic        ext;
   logic        out_t;
   logic        out_i;
   logic        irq_a;
   logic        irq_p;
   logic        src_go = 1'b0;
   logic [7:0]  src_n = 8'h00;
   logic [3:0]  src_half = 4'h3;
   logic        src_busy;
   logic [31:0] rd;
   logic        err;
   int          err_total = 0;
   int          check_count = 0;
   // ==========================================================================
   // Clock, design and the outside source.
   always #4 clk = !clk;
   tmc_core i_dut (.CLK_SYS_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(perr), .EXT_CLOCK_INPUT_I(ext), .OUT_TRUE_O(out_t),
      .OUT_INVERTED_O(out_i), .MATCH_A_IRQ_O(irq_a), .MATCH_P_IRQ_O(irq_p));
   // The source is wired straight to the input pin, as if pin sharing already routes it.
   tmc_ext_src i_src (.clk_i(clk), .start_i(src_go), .count_i(src_n), .half_i(src_half),
      .ext_o(ext), .busy_o(src_busy));
   // ==========================================================================
   // Shared tasks: verdict, compare and one bus transfer held until ready.
   task report_and_stop;
      if (err_total == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk(n < 20, 1'b1);
      rd = prdata;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   // Waits for one comparator pulse, counting comparator A pulses on the way.
   task automatic wait_irq(input logic p, output int na);
      int n;
      n = 0;
      na = 0;
      do begin
         @(posedge clk);
         n++;
         na += (irq_a === 1'b1);
      end while (((p ? irq_p : irq_a) !== 1'b1) && n < 400);
      chk(n < 400, 1'b1);
   endtask
   // ==========================================================================
   // Scenarios.
   task t_buffer;
      apb(1'b1, `TMC_CMPA_LOW_OFS, 32'h55);
      apb(1'b0, `TMC_CMPA_HIGH_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, `TMC_CMPA_LOW_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, `TMC_CMPA_LOW_OFS, 32'hA5);
      apb(1'b1, `TMC_CMPA_HIGH_OFS, 32'h2);
      apb(1'b0, `TMC_CMPA_HIGH_OFS, 32'h0);
      chk(rd, 32'h2);
      apb(1'b0, `TMC_CMPA_LOW_OFS, 32'h0);
      chk(rd, 32'hA5);
      apb(1'b0, 12'h01C, 32'h0);
      chk({rd[30:0], err}, 32'h1);
   endtask
   task automatic t_ext(input logic [7:0] c0, input logic [7:0] n, input logic [3:0] h);
      int w;
      w = 0;
      apb(1'b1, `TMC_CTRL0_OFS, 32'h0);
      apb(1'b1, `TMC_CTRL0_OFS, {24'h0, c0});
      src_n <= n;
      src_half <= h;
      src_go <= 1'b1;
      @(posedge clk);
      src_go <= 1'b0;
      @(posedge clk);
      while (src_busy && w < 2000) begin
         @(posedge clk);
         w++;
      end
      chk(w < 2000, 1'b1);
      repeat (10) @(posedge clk);
      apb(1'b0, `TMC_CNT_HIGH_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, `TMC_CNT_LOW_OFS, 32'h0);
      chk(rd, {24'h0, n});
   endtask
   task automatic t_match;
      int na;
      logic lvl;
      apb(1'b1, `TMC_CMPA_LOW_OFS, 32'h10);
      apb(1'b1, `TMC_CMPA_HIGH_OFS, 32'h0);
      apb(1'b1, `TMC_CTRL0_OFS, 32'h0);
      apb(1'b1, `TMC_CTRL1_OFS, 32'h30);
      apb(1'b1, `TMC_CTRL0_OFS, 32'h19);
      wait_irq(1'b1, na);
      wait_irq(1'b1, na);
      chk(na, 1);
      apb(1'b1, `TMC_CTRL0_OFS, 32'h0);
      apb(1'b1, `TMC_CTRL1_OFS, 32'h31);
      apb(1'b1, `TMC_CTRL0_OFS, 32'h19);
      wait_irq(1'b0, na);
      repeat (2) @(posedge clk);
      lvl = out_t;
      wait_irq(1'b0, na);
      repeat (2) @(posedge clk);
      chk(out_t, !lvl);
      na = 0;
      repeat (300) begin
         @(posedge clk);
         na += (irq_p === 1'b1);
      end
      chk(na, 0);
   endtask
   // Fixed PWM levels, one edge-aligned PWM period, then one triggered single pulse.
   // Comparator A still holds 0x010 from the match scenario.
   task automatic t_pwm;
      int na;
      apb(1'b1, `TMC_CTRL0_OFS, 32'h0);
      apb(1'b1, `TMC_CTRL1_OFS, 32'h90);
      @(posedge clk);
      chk(out_t, 1'b1);
      apb(1'b1, `TMC_CTRL1_OFS, 32'h80);
      @(posedge clk);
      chk(out_t, 1'b0);
      apb(1'b1, `TMC_CTRL1_OFS, 32'hA0);
      apb(1'b1, `TMC_CTRL0_OFS, 32'h19);
      wait_irq(1'b1, na);
      chk(out_t, 1'b1);
      wait_irq(1'b0, na);
      chk(out_t, 1'b0);
      apb(1'b1, `TMC_CTRL0_OFS, 32'h0);
      apb(1'b1, `TMC_CTRL1_OFS, 32'hB0);
      apb(1'b1, `TMC_CTRL0_OFS, 32'h19);
      src_n <= 8'd1;
      src_half <= 4'h3;
      src_go <= 1'b1;
      @(posedge clk);
      src_go <= 1'b0;
      repeat (12) @(posedge clk);
      chk(out_t, 1'b1);
      wait_irq(1'b0, na);
      chk(out_t, 1'b0);
      repeat (40) @(posedge clk);
      apb(1'b0, `TMC_STATUS_OFS, 32'h0);
      chk(rd, 32'h0);
   endtask
   // ==========================================================================
   // Main sequence and watchdog.
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(1'b0, `TMC_CTRL0_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, `TMC_CTRL1_OFS, 32'h0);
      chk({rd[31:1], out_i}, 32'h1);
      t_buffer;
      t_ext(8'h68, 8'd5, 4'h3);
      t_ext(8'h78, 8'd3, 4'h7);
      t_match;
      t_pwm;
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      report_and_stop;
   end
endmodule
bind tmc_core tmc_core_properties i_props (.CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I),
   .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
   .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
   .EXT_CLOCK_INPUT_I(EXT_CLOCK_INPUT_I), .OUT_TRUE_O(OUT_TRUE_O),
   .OUT_INVERTED_O(OUT_INVERTED_O), .MATCH_A_IRQ_O(MATCH_A_IRQ_O),
   .MATCH_P_IRQ_O(MATCH_P_IRQ_O));
